// ---- src/sdidma_pkg.sv ----
// Package for the DMA interrupt status block: offsets, fields, resets.
// Assumes an APB slave with 32-bit data and one word per register.
package sdidma_pkg;

  localparam logic [11:0] off_dma_status    = 12'h08c;
  localparam logic [11:0] off_dma_int_en    = 12'h090;
  localparam logic [11:0] off_desc_ptr      = 12'h094;
  localparam logic [11:0] off_buf_ptr       = 12'h098;
  localparam logic [11:0] off_edge_config   = 12'h800;

  // Status and enable bit positions
  localparam int bit_tx_done     = 0;
  localparam int bit_rx_done     = 1;
  localparam int bit_bus_fault   = 2;
  localparam int bit_no_desc     = 4;
  localparam int bit_card_fault  = 5;
  localparam int bit_normal      = 8;
  localparam int bit_abnormal    = 9;
  localparam int code_lsb        = 10;
  localparam int code_msb        = 12;
  localparam int own_bit         = 31;

  localparam logic [2:0] code_tx_abort = 3'h1;
  localparam logic [2:0] code_rx_abort = 3'h2;
  localparam logic [2:0] code_none     = 3'h0;

  // Edge configuration fields
  localparam int per_lsb = 0;
  localparam int low_lsb = 4;
  localparam int high_lsb = 8;
  localparam int slf_lsb = 12;
  localparam int sam_lsb = 15;
  localparam int drv_lsb = 18;

  localparam logic [31:0] zero_word      = 32'h0000_0000;
  localparam logic [31:0] edge_reset     = 32'h0000_0000;
  localparam logic [31:0] int_en_mask    = 32'h0000_0337;
  localparam logic [31:0] edge_mask      = 32'h001f_ffff;
  localparam logic [6:0]  card_none      = 7'h00;

  typedef logic [2:0] sdidma_phase_type;

endpackage : sdidma_pkg

// ---- src/sdidma_flag.sv ----
// One sticky status flag: set by an event, cleared by writing one.
// Assumes set and clear arrive synchronous to pclk.
`timescale 1ns/1ns
module sdidma_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set,
  input  wire logic clear,
  output logic      flag
);
  typedef struct packed {
    logic f;
  } sdidma_flag_state_type;

  sdidma_flag_state_type state;
  sdidma_flag_state_type next_state;

  always_comb begin
    next_state = state;
    // Set wins over a clear in the same cycle
    if (clear) begin
      next_state.f = 1'b0;
    end
    if (set) begin
      next_state.f = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flag = state.f;
endmodule : sdidma_flag

// ---- src/sdidma_edge_cfg.sv ----
// Card clock divider edge and phase configuration register.
// Assumes the APB decode in the parent supplies the write strobe.
`timescale 1ns/1ns
module sdidma_edge_cfg (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr,
  input  wire logic [31:0] wdata,
  output logic      [31:0] value,
  output logic      [3:0]  divider_period_count,
  output logic      [3:0]  divider_low_count,
  output logic      [3:0]  divider_high_count,
  output logic      [2:0]  internal_phase_select,
  output logic      [2:0]  sample_phase_select,
  output logic      [2:0]  drive_phase_select
);
  typedef struct packed {
    logic [31:0] word;
  } sdidma_edge_state_type;

  sdidma_edge_state_type state;
  sdidma_edge_state_type next_state;

  always_comb begin
    next_state = state;
    // Software keeps low > high and period == low
    if (wr) begin
      next_state.word = wdata & sdidma_pkg::edge_mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= sdidma_pkg::edge_reset;
    end else begin
      state <= next_state;
    end
  end

  assign value = state.word;
  assign divider_period_count  = state.word[sdidma_pkg::per_lsb +: 4];
  assign divider_low_count     = state.word[sdidma_pkg::low_lsb +: 4];
  assign divider_high_count    = state.word[sdidma_pkg::high_lsb +: 4];
  assign internal_phase_select = state.word[sdidma_pkg::slf_lsb +: 3]; // R17
  assign sample_phase_select   = state.word[sdidma_pkg::sam_lsb +: 3]; // R17
  assign drive_phase_select    = state.word[sdidma_pkg::drv_lsb +: 3]; // R17
endmodule : sdidma_edge_cfg

// ---- src/sdidma_top.sv ----
// Interrupt status, enable and pointer registers of the descriptor DMA.
// Assumes an APB master on pclk and event pulses from the DMA and card unit.
//
// What this block does
// R1: Abnormal summary is OR of enabled bus fault and no-descriptor flags.
// R2: Normal summary is OR of enabled transmit-done and receive-done flags.
// R3: Summary bits are sticky, write one clears; software reclears them.
// R4: Card fault summary is OR of seven card causes; write one clears.
// R5: With card fault enable set, DMA aborts on card response error.
// R6: No-descriptor flag sets when descriptor ownership bit 31 is zero.
// R7: Bus fault sets flag, records 3-bit code at 12:10, halts bus.
// R8: Receive-done flag sets when a descriptor is received; write one clears.
// R9: Transmit-done flag sets when a descriptor is sent; write one clears.
// R10: Abnormal group enable gates bus fault and no-descriptor enables.
// R11: Normal group enable gates transmit-done and receive-done enables.
// R12: Each cause except card fault needs its own enable and its group enable.
// R13: Card fault enable turns the card fault summary interrupt on.
// R14: Read-only descriptor pointer tracks current descriptor; zero at reset.
// R15: Read-only buffer pointer tracks current buffer; zero at reset.
// R16: Software programs low count above high, period equal to low.
// R17: Separate internal, sample and drive phase selects: 90, 180, 270.
// R18: Bus fault code 001 tx abort, 010 rx abort; valid while flag.
// R19: One interrupt output high while any enabled summary bit is set.
`timescale 1ns/1ns
module sdidma_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_done,
  input  wire logic        rx_done,
  input  wire logic        desc_fetched,
  input  wire logic [31:0] descriptor_word_zero,
  input  wire logic        host_abort_tx,
  input  wire logic        host_abort_rx,
  input  wire logic [6:0]  card_causes,
  input  wire logic        card_response_error,
  input  wire logic        desc_ptr_load,
  input  wire logic [31:0] desc_ptr_value,
  input  wire logic        buf_ptr_load,
  input  wire logic [31:0] buf_ptr_value,
  output logic             dma_abort,
  output logic             bus_halt,
  output logic             irq,
  output logic      [3:0]  divider_period_count,
  output logic      [3:0]  divider_low_count,
  output logic      [3:0]  divider_high_count,
  output logic      [2:0]  internal_phase_select,
  output logic      [2:0]  sample_phase_select,
  output logic      [2:0]  drive_phase_select
);
  typedef struct packed {
    logic        tx_done_enable;
    logic        rx_done_enable;
    logic        bus_fault_enable;
    logic        no_descriptor_enable;
    logic        card_fault_enable;
    logic        normal_group_enable;
    logic        abnormal_group_enable;
    logic [2:0]  bus_fault_code;
    logic [31:0] descriptor_pointer;
    logic [31:0] buffer_pointer;
    logic [31:0] rdata;
    logic        abort;
  } sdidma_state_type;

  sdidma_state_type state;
  sdidma_state_type next_state;

  logic        wr_access;
  logic        rd_access;
  logic        mapped;
  logic        wr_status;
  logic        wr_edge;
  logic [31:0] edge_value;
  logic [31:0] status_word;
  logic [31:0] enable_word;
  logic        bus_fault_event;
  logic        no_desc_event;
  logic        card_event;
  logic        en_tx;
  logic        en_rx;
  logic        en_bus;
  logic        en_desc;
  logic        normal_set;
  logic        abnormal_set;

  // Flags in order: tx, rx, bus fault, no desc, card, normal, abnormal
  localparam int n_flags = 7;
  logic [n_flags-1:0] flag_set;
  logic [n_flags-1:0] flag_clr;
  logic [n_flags-1:0] flags;
  logic [n_flags-1:0] flag_pos_hit;
  int                 flag_pos [n_flags];

  assign flag_pos[0] = sdidma_pkg::bit_tx_done;
  assign flag_pos[1] = sdidma_pkg::bit_rx_done;
  assign flag_pos[2] = sdidma_pkg::bit_bus_fault;
  assign flag_pos[3] = sdidma_pkg::bit_no_desc;
  assign flag_pos[4] = sdidma_pkg::bit_card_fault;
  assign flag_pos[5] = sdidma_pkg::bit_normal;
  assign flag_pos[6] = sdidma_pkg::bit_abnormal;

  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && !penable && !pwrite;
  assign wr_status = wr_access && (paddr == sdidma_pkg::off_dma_status);
  assign wr_edge   = wr_access && (paddr == sdidma_pkg::off_edge_config);
  assign mapped    = (paddr == sdidma_pkg::off_dma_status)
                  || (paddr == sdidma_pkg::off_dma_int_en)
                  || (paddr == sdidma_pkg::off_desc_ptr)
                  || (paddr == sdidma_pkg::off_buf_ptr)
                  || (paddr == sdidma_pkg::off_edge_config);

  // Raw events
  assign no_desc_event = desc_fetched
                      && !descriptor_word_zero[sdidma_pkg::own_bit]; // R6
  assign bus_fault_event = host_abort_tx || host_abort_rx; // R7
  assign card_event = |card_causes; // R4

  // Individual enables qualified by their group
  assign en_tx   = state.tx_done_enable && state.normal_group_enable; // R11
  assign en_rx   = state.rx_done_enable && state.normal_group_enable; // R12
  assign en_bus  = state.bus_fault_enable
                && state.abnormal_group_enable; // R10
  assign en_desc = state.no_descriptor_enable
                && state.abnormal_group_enable; // R12

  assign normal_set   = (flags[0] && en_tx) || (flags[1] && en_rx); // R2
  assign abnormal_set = (flags[2] && en_bus) || (flags[3] && en_desc); // R1

  assign flag_set[0] = tx_done; // R9
  assign flag_set[1] = rx_done; // R8
  assign flag_set[2] = bus_fault_event; // R7
  assign flag_set[3] = no_desc_event; // R6
  assign flag_set[4] = card_event; // R4
  assign flag_set[5] = normal_set; // R3
  assign flag_set[6] = abnormal_set; // R3

  genvar gi;
  generate
    for (gi = 0; gi < n_flags; gi++) begin : g_flag
      assign flag_pos_hit[gi] = pwdata[flag_pos[gi]];
      assign flag_clr[gi] = wr_status && flag_pos_hit[gi]; // R3
      sdidma_flag u_flag (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (flag_set[gi]),
        .clear   (flag_clr[gi]),
        .flag    (flags[gi])
      );
    end
  endgenerate

  sdidma_edge_cfg u_edge (
    .pclk                  (pclk),
    .presetn               (presetn),
    .wr                    (wr_edge),
    .wdata                 (pwdata),
    .value                 (edge_value),
    .divider_period_count  (divider_period_count),
    .divider_low_count     (divider_low_count),
    .divider_high_count    (divider_high_count),
    .internal_phase_select (internal_phase_select),
    .sample_phase_select   (sample_phase_select),
    .drive_phase_select    (drive_phase_select)
  );

  always_comb begin
    status_word = sdidma_pkg::zero_word;
    status_word[sdidma_pkg::bit_tx_done]    = flags[0];
    status_word[sdidma_pkg::bit_rx_done]    = flags[1];
    status_word[sdidma_pkg::bit_bus_fault]  = flags[2];
    status_word[sdidma_pkg::bit_no_desc]    = flags[3];
    status_word[sdidma_pkg::bit_card_fault] = flags[4];
    status_word[sdidma_pkg::bit_normal]     = flags[5];
    status_word[sdidma_pkg::bit_abnormal]   = flags[6];
    // Code reads only while the bus fault flag stands
    if (flags[2]) begin
      status_word[sdidma_pkg::code_msb:sdidma_pkg::code_lsb] =
        state.bus_fault_code; // R18
    end
  end

  always_comb begin
    enable_word = sdidma_pkg::zero_word;
    enable_word[sdidma_pkg::bit_tx_done]    = state.tx_done_enable;
    enable_word[sdidma_pkg::bit_rx_done]    = state.rx_done_enable;
    enable_word[sdidma_pkg::bit_bus_fault]  = state.bus_fault_enable;
    enable_word[sdidma_pkg::bit_no_desc]    = state.no_descriptor_enable;
    enable_word[sdidma_pkg::bit_card_fault] = state.card_fault_enable;
    enable_word[sdidma_pkg::bit_normal]     = state.normal_group_enable;
    enable_word[sdidma_pkg::bit_abnormal]   = state.abnormal_group_enable;
  end

  always_comb begin
    next_state = state;
    if (wr_access && (paddr == sdidma_pkg::off_dma_int_en)) begin
      next_state.tx_done_enable = pwdata[sdidma_pkg::bit_tx_done];
      next_state.rx_done_enable = pwdata[sdidma_pkg::bit_rx_done];
      next_state.bus_fault_enable = pwdata[sdidma_pkg::bit_bus_fault];
      next_state.no_descriptor_enable = pwdata[sdidma_pkg::bit_no_desc];
      next_state.card_fault_enable = pwdata[sdidma_pkg::bit_card_fault];
      next_state.normal_group_enable = pwdata[sdidma_pkg::bit_normal];
      next_state.abnormal_group_enable = pwdata[sdidma_pkg::bit_abnormal];
    end
    // Latest abort type is kept; transmit wins when both arrive
    if (host_abort_tx) begin
      next_state.bus_fault_code = sdidma_pkg::code_tx_abort; // R18
    end else if (host_abort_rx) begin
      next_state.bus_fault_code = sdidma_pkg::code_rx_abort; // R18
    end else if (flag_clr[2] && !flags[2]) begin
      next_state.bus_fault_code = sdidma_pkg::code_none;
    end
    if (desc_ptr_load) begin
      next_state.descriptor_pointer = desc_ptr_value; // R14
    end
    if (buf_ptr_load) begin
      next_state.buffer_pointer = buf_ptr_value; // R15
    end
    // Abort to the DMA engine follows the card response error one cycle later, while card fault enable is set, for as long as it is held
    next_state.abort = card_response_error && state.card_fault_enable; // R5
    if (rd_access) begin
      unique case (paddr)
        sdidma_pkg::off_dma_status:  next_state.rdata = status_word;
        sdidma_pkg::off_dma_int_en:  next_state.rdata = enable_word;
        sdidma_pkg::off_desc_ptr:    next_state.rdata =
                                       state.descriptor_pointer;
        sdidma_pkg::off_buf_ptr:     next_state.rdata = state.buffer_pointer;
        sdidma_pkg::off_edge_config: next_state.rdata = edge_value;
        default:                     next_state.rdata = sdidma_pkg::zero_word;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0; // R14 R15
    end else begin
      state <= next_state;
    end
  end

  assign prdata   = state.rdata;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign dma_abort = state.abort;
  assign bus_halt = flags[2]; // R7
  assign irq = (flags[5] && state.normal_group_enable)
            || (flags[6] && state.abnormal_group_enable)
            || (flags[4] && state.card_fault_enable); // R19 R13
endmodule : sdidma_top

// ---- bench/sdidma_monitor.sv ----
// Checker for the DMA interrupt block, watching top-level ports only.
// Assumes one clock pclk and an asynchronous active-low presetn.
`timescale 1ns/1ns
module sdidma_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        tx_done,
  input wire logic        rx_done,
  input wire logic        desc_fetched,
  input wire logic [31:0] descriptor_word_zero,
  input wire logic        host_abort_tx,
  input wire logic        host_abort_rx,
  input wire logic [6:0]  card_causes,
  input wire logic        card_response_error,
  input wire logic        desc_ptr_load,
  input wire logic [31:0] desc_ptr_value,
  input wire logic        buf_ptr_load,
  input wire logic [31:0] buf_ptr_value,
  input wire logic        dma_abort,
  input wire logic        bus_halt,
  input wire logic        irq
);
  localparam logic [11:0] st_a = sdidma_pkg::off_dma_status;
  localparam logic [11:0] dp_a = sdidma_pkg::off_desc_ptr;
  localparam logic [11:0] bp_a = sdidma_pkg::off_buf_ptr;
  logic cause;
  // Anything that may legally raise the request line
  assign cause = tx_done || rx_done || desc_fetched || host_abort_tx ||
                 host_abort_rx || (|card_causes) || (psel && penable && pwrite);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_rd(logic [11:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  a_tx_flag_set: assert property (
    tx_done ##1 s_rd(st_a) |=> prdata[0]) else $error("tx flag not set");
  a_rx_flag_set: assert property (
    rx_done ##1 s_rd(st_a) |=> prdata[1]) else $error("rx flag not set");
  a_desc_flag_set: assert property (
    desc_fetched && !descriptor_word_zero[31] ##1 s_rd(st_a) |=> prdata[4])
    else $error("no-descriptor flag not set");
  a_card_flag_set: assert property (
    card_causes != 7'h00 ##1 s_rd(st_a) |=> prdata[5])
    else $error("card fault flag not set");
  a_tx_fault_code: assert property (
    host_abort_tx && !host_abort_rx && !bus_halt ##1 s_rd(st_a)
    |=> prdata[12:10] == 3'h1 && prdata[2]) else $error("tx code wrong");
  a_rx_fault_code: assert property (
    host_abort_rx && !host_abort_tx && !bus_halt ##1 s_rd(st_a)
    |=> prdata[12:10] == 3'h2 && prdata[2]) else $error("rx code wrong");
  a_fault_halts_bus: assert property (
    host_abort_tx || host_abort_rx |=> bus_halt) else $error("no halt");
  a_abort_has_cause: assert property (
    dma_abort |-> $past(card_response_error)) else $error("stray abort");
  a_desc_ptr_load: assert property (
    desc_ptr_load ##1 s_rd(dp_a) |=> prdata == $past(desc_ptr_value, 2))
    else $error("descriptor pointer wrong");
  a_buf_ptr_load: assert property (
    buf_ptr_load ##1 s_rd(bp_a) |=> prdata == $past(buf_ptr_value, 2))
    else $error("buffer pointer wrong");
  a_irq_has_cause: assert property (
    $rose(irq) |-> $past(cause) || $past(cause, 2)) else $error("stray irq");
endmodule : sdidma_monitor

bind sdidma_top sdidma_monitor u_monitor (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .tx_done,
  .rx_done, .desc_fetched, .descriptor_word_zero, .host_abort_tx,
  .host_abort_rx, .card_causes, .card_response_error, .desc_ptr_load,
  .desc_ptr_value, .buf_ptr_load, .buf_ptr_value, .dma_abort, .bus_halt,
  .irq
);

// ---- bench/test_sd_host_dma_interrupt_status.sv ----
// Self-checking bench for the DMA interrupt status block.
// Assumes an APB slave at zero wait states and pulsed event inputs.
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module test_sd_host_dma_interrupt_status;
  typedef struct packed {
    logic [2:0]  ev;
    logic [6:0]  cc;
    logic [15:0] en;
    logic [15:0] st;
    logic        irq;
  } sdidma_row_type;
  localparam logic [11:0] ad_st = sdidma_pkg::off_dma_status;
  localparam logic [11:0] ad_en = sdidma_pkg::off_dma_int_en;
  localparam logic [11:0] ad_dp = sdidma_pkg::off_desc_ptr;
  localparam logic [11:0] ad_bp = sdidma_pkg::off_buf_ptr;
  localparam logic [11:0] ad_ec = sdidma_pkg::off_edge_config;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        tx_done, rx_done, desc_fetched, host_abort_tx, host_abort_rx;
  logic        card_response_error, desc_ptr_load, buf_ptr_load;
  logic        dma_abort, bus_halt, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, descriptor_word_zero, rd;
  logic [31:0] desc_ptr_value, buf_ptr_value;
  logic [6:0]  card_causes;
  logic [3:0]  divider_period_count, divider_low_count, divider_high_count;
  logic [2:0]  internal_phase_select, sample_phase_select, drive_phase_select;
  logic [15:0] mk;
  int          fails, checks_done, cyc;
  sdidma_row_type r;
  sdidma_row_type rows [12] = '{
    '{3'h0, 7'h00, 16'h0101, 16'h0101, 1'b1},
    '{3'h1, 7'h00, 16'h0102, 16'h0102, 1'b1},
    '{3'h0, 7'h00, 16'h0001, 16'h0001, 1'b0},
    '{3'h1, 7'h00, 16'h0101, 16'h0002, 1'b0},
    '{3'h2, 7'h00, 16'h0204, 16'h0604, 1'b1},
    '{3'h3, 7'h00, 16'h0004, 16'h0804, 1'b0},
    '{3'h3, 7'h00, 16'h0200, 16'h0804, 1'b0},
    '{3'h4, 7'h00, 16'h0210, 16'h0210, 1'b1},
    '{3'h4, 7'h00, 16'h0010, 16'h0010, 1'b0},
    '{3'h5, 7'h00, 16'h0210, 16'h0000, 1'b0},
    '{3'h6, 7'h01, 16'h0020, 16'h0020, 1'b1},
    '{3'h6, 7'h40, 16'h0000, 16'h0020, 1'b0}
  };
  sdidma_top dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tx_done, .rx_done, .desc_fetched,
    .descriptor_word_zero, .host_abort_tx, .host_abort_rx, .card_causes,
    .card_response_error, .desc_ptr_load, .desc_ptr_value, .buf_ptr_load,
    .buf_ptr_value, .dma_abort, .bus_halt, .irq, .divider_period_count,
    .divider_low_count, .divider_high_count, .internal_phase_select,
    .sample_phase_select, .drive_phase_select
  );
  always #50 pclk = ~pclk;
  task automatic complete_run;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      complete_run();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the slave; only the bench timeout ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic ev(input logic [2:0] k, input logic [6:0] c);
    @(posedge pclk);
    tx_done <= k == 3'h0;
    rx_done <= k == 3'h1;
    host_abort_tx <= k == 3'h2;
    host_abort_rx <= k == 3'h3;
    desc_fetched <= k[2] && !k[1];
    descriptor_word_zero <= {k == 3'h5, 31'h0000_4a20};
    card_causes <= (k == 3'h6) ? c : sdidma_pkg::card_none;
    @(posedge pclk);
    {tx_done, rx_done, host_abort_tx, host_abort_rx, desc_fetched} <= 5'h0;
    card_causes <= sdidma_pkg::card_none;
  endtask : ev
  // Reads status in the cycle right after the event lands
  task automatic evrd(input logic [2:0] k, input logic [6:0] c);
    fork
      ev(k, c);
      begin
        @(posedge pclk);
        apb(1'b0, ad_st, 32'h0000_0000);
      end
    join
  endtask : evrd
  task automatic ld(input logic b, input logic [31:0] v);
    @(posedge pclk);
    desc_ptr_load <= !b;
    buf_ptr_load <= b;
    desc_ptr_value <= v;
    buf_ptr_value <= v;
    fork
      apb(1'b0, b ? ad_bp : ad_dp, 32'h0000_0000);
      begin
        @(posedge pclk);
        desc_ptr_load <= 1'b0;
        buf_ptr_load <= 1'b0;
        desc_ptr_value <= ~v;
      end
    join
    `CHK(rd, v)
  endtask : ld
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, tx_done, rx_done, desc_fetched} = 6'h0;
    {host_abort_tx, host_abort_rx, card_response_error} = 3'h0;
    {desc_ptr_load, buf_ptr_load} = 2'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    descriptor_word_zero = 32'h0000_0000;
    desc_ptr_value = 32'h0000_0000;
    buf_ptr_value = 32'h0000_0000;
    card_causes = 7'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      mk = ~(16'h0300 & ~r.en);
      apb(1'b1, ad_en, {16'h0000, r.en});
      evrd(r.ev, r.cc);
      `CHK(rd & 32'h0000_1c37, {16'h0000, r.st} & 32'h0000_1c37)
      repeat (2) @(posedge pclk);
      `CHK(irq, r.irq)
      `CHK(bus_halt, r.st[2])
      apb(1'b0, ad_st, 32'h0000_0000);
      `CHK(rd & {16'hffff, mk}, {16'h0000, r.st})
      apb(1'b1, ad_st, 32'h0000_0337);
      apb(1'b0, ad_st, 32'h0000_0000);
      `CHK(rd & {16'hffff, mk}, {16'h0000, r.st & 16'h0300})
      apb(1'b1, ad_st, 32'h0000_0337);
      apb(1'b0, ad_st, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      `CHK(irq, 1'b0)
    end
    for (int i = 0; i < 7; i++) begin
      evrd(3'h6, 7'h01 << i);
      `CHK(rd[5], 1'b1)
      apb(1'b1, ad_st, 32'h0000_0337);
    end
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, ad_en, j == 0 ? 32'h0000_0020 : 32'h0000_0000);
      @(posedge pclk);
      card_response_error <= 1'b1;
      @(posedge pclk);
      card_response_error <= 1'b0;
      @(negedge pclk);
      `CHK(dma_abort, j == 0)
    end
    apb(1'b1, ad_en, 32'hffff_ffff);
    apb(1'b0, ad_en, 32'h0000_0000);
    `CHK(rd, sdidma_pkg::int_en_mask)
    apb(1'b1, ad_ec, 32'hffed_1266);
    apb(1'b0, ad_ec, 32'h0000_0000);
    `CHK(rd, 32'h000d_1266)
    `CHK({divider_period_count, divider_low_count, divider_high_count,
          internal_phase_select, sample_phase_select, drive_phase_select},
         {4'h6, 4'h6, 4'h2, 3'h1, 3'h2, 3'h3})
    ld(1'b0, 32'h1234_5670);
    ld(1'b1, 32'h2000_0040);
    apb(1'b1, ad_dp, 32'hffff_ffff);
    apb(1'b0, ad_dp, 32'h0000_0000);
    `CHK(rd, 32'h1234_5670)
    apb(1'b0, 12'h0a0, 32'h0000_0000);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    `CHK(pready, 1'b1)
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) if (i < 5) begin
      apb(1'b0, i == 0 ? ad_st : i == 1 ? ad_en : i == 2 ? ad_dp :
          i == 3 ? ad_bp : ad_ec, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
    end
    `CHK({irq, bus_halt, dma_abort}, 3'h0)
    complete_run();
  end
endmodule : test_sd_host_dma_interrupt_status
